/* design/flash_status_pkg.sv */
package flash_status_pkg;

    // Serial command that starts a status read
    localparam logic [7:0] STATUS_READ_OPCODE = 8'hD7;
    // Density class code (arbitrary value, backward-compatibility field)
    localparam logic [3:0] DENSITY_CODE = 4'h5;

    // First status byte field positions
    localparam int B1_READY_POS = 7;
    localparam int B1_COMPARE_POS = 6;
    localparam int B1_DENSITY_LSB = 2;
    localparam int B1_PROTECT_POS = 1;
    localparam int B1_PAGE_POS = 0;

    // Second status byte (status_byte_two) field positions
    localparam int B2_READY_POS = 7;
    localparam int B2_RSVD_HI_POS = 6;
    localparam int B2_FAULT_POS = 5;
    localparam int B2_RSVD_LO_POS = 4;
    localparam int B2_LOCKDOWN_POS = 3;
    localparam int B2_BUF2_POS = 2;
    localparam int B2_BUF1_POS = 1;
    localparam int B2_ERASE_POS = 0;

    // Reset values
    localparam logic FAULT_RESET = 1'b0;
    localparam logic COMPARE_RESET = 1'b0;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;

    // Bits in a byte, minus one
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_STATUS,
        ST_IGNORE
    } link_state_type;

endpackage

/* design/flash_status_register.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_status_register
    import flash_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    input wire logic i_busy,
    input wire logic i_op_done,
    input wire logic i_op_failed,
    input wire logic i_op_aborted,
    input wire logic i_compare_done,
    input wire logic i_compare_differs,
    input wire logic i_protect_enabled,
    input wire logic i_binary_page,
    input wire logic i_lockdown_allowed,
    input wire logic i_buf2_program_paused,
    input wire logic i_buf1_program_paused,
    input wire logic i_erase_paused,
    input wire logic i_buf1_write_req,
    input wire logic i_buf2_write_req,
    output logic o_buf1_write_en,
    output logic o_buf2_write_en,
    output logic [7:0] o_status_byte_two
);
    logic sck_s;
    logic cs_n_s;
    logic si_s;
    logic sck_prev_q;
    logic sck_prev_d;
    logic sck_rise;
    logic sck_fall;
    link_state_type state_q;
    link_state_type state_d;
    logic [2:0] bit_cnt_q;
    logic [2:0] bit_cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic byte_sel_q;
    logic byte_sel_d;
    logic so_q;
    logic so_d;
    logic so_oe_q;
    logic so_oe_d;
    logic fault_q;
    logic fault_d;
    logic compare_q;
    logic compare_d;
    logic [7:0] byte_one;
    logic [7:0] byte_two;
    logic [7:0] opcode_word;

    pin_sync u_sync_sck (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async(i_sck),
        .i_reset_level(1'b0),
        .o_sync(sck_s)
    );

    pin_sync u_sync_cs (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async(i_cs_n),
        .i_reset_level(1'b1),
        .o_sync(cs_n_s)
    );

    pin_sync u_sync_si (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async(i_si),
        .i_reset_level(1'b0),
        .o_sync(si_s)
    );

    status_word_builder u_words (
        .i_busy(i_busy),
        .i_compare_differs(compare_q),
        .i_protect_enabled(i_protect_enabled),
        .i_binary_page(i_binary_page),
        .i_fault(fault_q),
        .i_lockdown_allowed(i_lockdown_allowed),
        .i_buf2_program_paused(i_buf2_program_paused),
        .i_buf1_program_paused(i_buf1_program_paused),
        .i_erase_paused(i_erase_paused),
        .o_byte_one(byte_one),
        .o_status_byte_two(byte_two)
    );

    // Fault and compare results are held here between operations
    always_comb
    begin
        fault_d = fault_q;
        compare_d = compare_q;
        if (i_op_done)
        begin
            // An abort never reports a fault, even if the array flagged one
            fault_d = i_op_failed & ~i_op_aborted;
        end
        if (i_compare_done)
        begin
            compare_d = i_compare_differs;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            fault_q <= FAULT_RESET;
            compare_q <= COMPARE_RESET;
        end
        else
        begin
            fault_q <= fault_d;
            compare_q <= compare_d;
        end
    end

    // Suspended buffers refuse every write that would alter them
    assign o_buf1_write_en = i_buf1_write_req & ~i_buf1_program_paused;
    assign o_buf2_write_en = i_buf2_write_req & ~i_buf2_program_paused;
    assign o_status_byte_two = byte_two;

    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;
    assign opcode_word = {shift_q[6:0], si_s};

    // Mode 0/3 style: sample on rising edge, launch on falling edge
    always_comb
    begin
        sck_prev_d = sck_s;
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        byte_sel_d = byte_sel_q;
        so_d = so_q;
        so_oe_d = so_oe_q;
        if (cs_n_s)
        begin
            state_d = ST_IDLE;
            so_oe_d = 1'b0;
            bit_cnt_d = BIT_CNT_RESET;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    state_d = ST_OPCODE;
                    bit_cnt_d = BIT_CNT_RESET;
                    shift_d = SHIFT_RESET;
                end
                ST_OPCODE:
                begin
                    if (sck_rise)
                    begin
                        shift_d = opcode_word;
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        if (bit_cnt_q == LAST_BIT)
                        begin
                            if (opcode_word == STATUS_READ_OPCODE)
                            begin
                                state_d = ST_STATUS;
                                byte_sel_d = 1'b0;
                            end
                            else
                            begin
                                state_d = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_STATUS:
                begin
                    if (sck_fall)
                    begin
                        if (bit_cnt_q == BIT_CNT_RESET)
                        begin
                            // Whole byte captured at once keeps its bits coherent
                            shift_d = byte_sel_q ? byte_two : byte_one;
                            so_d = byte_sel_q ? byte_two[7] : byte_one[7];
                            byte_sel_d = ~byte_sel_q;
                        end
                        else
                        begin
                            so_d = shift_q[7];
                        end
                        so_oe_d = 1'b1;
                    end
                    if (sck_rise && so_oe_q)
                    begin
                        shift_d = {shift_q[6:0], 1'b0};
                        bit_cnt_d = bit_cnt_q + 3'h1;
                    end
                end
                ST_IGNORE:
                begin
                    state_d = ST_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sck_prev_q <= 1'b0;
            state_q <= ST_IDLE;
            bit_cnt_q <= BIT_CNT_RESET;
            shift_q <= SHIFT_RESET;
            byte_sel_q <= 1'b0;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end
        else
        begin
            sck_prev_q <= sck_prev_d;
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            byte_sel_q <= byte_sel_d;
            so_q <= so_d;
            so_oe_q <= so_oe_d;
        end
    end

    assign o_so = so_q;
    assign o_so_oe = so_oe_q;

    ready_mirror_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_status_byte_two[7] == ~i_busy)
        else $error("ready bit does not mirror busy");

    reserved_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_status_byte_two[6] == 1'b0 && o_status_byte_two[4] == 1'b0)
        else $error("reserved bit not zero");

    fault_abort_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_op_done && i_op_aborted |=> !o_status_byte_two[5])
        else $error("fault set by aborted operation");

    fault_update_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_op_done && i_op_failed && !i_op_aborted |=> o_status_byte_two[5] && fault_q)
        else $error("fault not set by failure");

    fault_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !i_op_done |=> $stable(fault_q))
        else $error("fault changed without an operation end");

    buf_block_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_buf2_program_paused |-> !o_buf2_write_en)
        else $error("buffer 2 written while suspended");

    buf1_block_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_buf1_program_paused |-> !o_buf1_write_en)
        else $error("buffer 1 written while suspended");

    deselect_release_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        cs_n_s |=> !o_so_oe)
        else $error("output driven after deselect");

    erase_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_status_byte_two[0] == i_erase_paused)
        else $error("erase suspend flag wrong");
endmodule
`default_nettype wire

/* design/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_sync
    import flash_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_async,
    input wire logic i_reset_level,
    output logic o_sync
);
    logic meta_q;
    logic sync_q;
    logic meta_d;
    logic sync_d;

    always_comb
    begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    // Reset to the pin's idle level so no false edge appears at release
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d ^ i_reset_level;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q ^ i_reset_level;
endmodule
`default_nettype wire

/* design/status_word_builder.sv */
`timescale 1ns/1ns
`default_nettype none
module status_word_builder
    import flash_status_pkg::*;
(
    input wire logic i_busy,
    input wire logic i_compare_differs,
    input wire logic i_protect_enabled,
    input wire logic i_binary_page,
    input wire logic i_fault,
    input wire logic i_lockdown_allowed,
    input wire logic i_buf2_program_paused,
    input wire logic i_buf1_program_paused,
    input wire logic i_erase_paused,
    output logic [7:0] o_byte_one,
    output logic [7:0] o_status_byte_two
);
    always_comb
    begin
        o_byte_one = 8'h00;
        o_byte_one[B1_READY_POS] = ~i_busy;
        o_byte_one[B1_COMPARE_POS] = i_compare_differs;
        o_byte_one[B1_DENSITY_LSB +: 4] = DENSITY_CODE;
        o_byte_one[B1_PROTECT_POS] = i_protect_enabled;
        o_byte_one[B1_PAGE_POS] = i_binary_page;
        o_status_byte_two = 8'h00;
        o_status_byte_two[B2_READY_POS] = ~i_busy;
        o_status_byte_two[B2_RSVD_HI_POS] = 1'b0;
        o_status_byte_two[B2_FAULT_POS] = i_fault;
        o_status_byte_two[B2_RSVD_LO_POS] = 1'b0;
        o_status_byte_two[B2_LOCKDOWN_POS] = i_lockdown_allowed;
        o_status_byte_two[B2_BUF2_POS] = i_buf2_program_paused;
        o_status_byte_two[B2_BUF1_POS] = i_buf1_program_paused;
        o_status_byte_two[B2_ERASE_POS] = i_erase_paused;
    end
endmodule
`default_nettype wire

/* tb/spi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so,
    input wire logic i_so_oe
);
    logic [31:0] rx_q;
    logic oe_seen_q;
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        rx_q = 32'h0;
        oe_seen_q = 1'b0;
    end
    // Mode 0: clock idles low between frames, data taken on the rise
    task automatic frame(input logic [7:0] op, input int nbits);
        rx_q = 32'h0;
        oe_seen_q = 1'b0;
        #13 o_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            o_si = op[i];
            #200 o_sck = 1'b1;
            #200 o_sck = 1'b0;
        end
        for (int i = 0; i < nbits; i++)
        begin
            // Opcode is over; keep the line moving so no stale level rests on it
            o_si = ~o_si;
            #200 o_sck = 1'b1;
            // A released line is read as the inverse, so an undriven bit never passes
            rx_q = {rx_q[30:0], i_so_oe ? i_so : ~i_so};
            oe_seen_q = oe_seen_q | i_so_oe;
            #200 o_sck = 1'b0;
        end
        #100 o_cs_n = 1'b1;
        #300;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import flash_status_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sck, cs_n, si, so, so_oe;
    logic busy, done, failed, aborted, cmp_done, cmp_diff;
    logic wr1, wr2, en1, en2;
    logic [5:0] lv;
    logic [7:0] sb2;
    logic [15:0] e1, e2;
    logic fault_e, cmp_e;
    int err_count = 0;
    int total_checks = 0;
    logic [1:0] op_seq [4] = '{2'b10, 2'b11, 2'b10, 2'b00};

    always #25 clk = ~clk;

    flash_status_register DUT (.i_core_clk(clk), .i_rstn(rstn), .i_sck(sck), .i_cs_n(cs_n),
        .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_busy(busy), .i_op_done(done),
        .i_op_failed(failed), .i_op_aborted(aborted), .i_compare_done(cmp_done),
        .i_compare_differs(cmp_diff), .i_protect_enabled(lv[5]), .i_binary_page(lv[4]),
        .i_lockdown_allowed(lv[3]), .i_buf2_program_paused(lv[2]),
        .i_buf1_program_paused(lv[1]), .i_erase_paused(lv[0]), .i_buf1_write_req(wr1),
        .i_buf2_write_req(wr2), .o_buf1_write_en(en1), .o_buf2_write_en(en2),
        .o_status_byte_two(sb2));

    spi_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));

    function automatic logic [15:0] exp_pair();
        return {~busy, cmp_e, DENSITY_CODE, lv[5], lv[4],
                ~busy, 1'b0, fault_e, 1'b0, lv[3:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: value %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic read_check();
        tick(4);
        e1 = exp_pair();
        check({24'h0, sb2}, {24'h0, e1[7:0]});
        host.frame(STATUS_READ_OPCODE, 32);
        check(host.rx_q, {e1, e1});
    endtask

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_count);
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        err_count++;
        finish_test();
    end

    initial
    begin
        {busy, done, failed, aborted, cmp_done, cmp_diff, wr1, wr2} = 8'h00;
        lv = 6'h00;
        fault_e = 1'b0;
        cmp_e = 1'b0;
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        read_check();
        check({31'h0, en1 | en2}, 32'h0);
        end_test("reset");
        wr1 = 1'b1;
        wr2 = 1'b1;
        for (int i = 0; i <= 6; i++)
        begin
            lv = (i == 6) ? 6'h3F : (6'h01 << i);
            read_check();
            check({30'h0, en2, en1}, {30'h0, ~lv[2], ~lv[1]});
        end
        lv = 6'h00;
        end_test("flags");
        // Fail, aborted fail, fail, clean pass: flag follows the latest outcome
        foreach (op_seq[i])
        begin
            tick(1);
            {done, failed, aborted} = {1'b1, op_seq[i]};
            tick(1);
            {done, failed, aborted} = 3'h0;
            fault_e = op_seq[i][1] & ~op_seq[i][0];
            read_check();
        end
        end_test("fault");
        for (int i = 1; i >= 0; i--)
        begin
            {cmp_done, cmp_diff} = {1'b1, i[0]};
            tick(1);
            cmp_done = 1'b0;
            // Flip the result line after the strobe: only the latched value may show
            cmp_diff = ~i[0];
            cmp_e = i[0];
            read_check();
        end
        end_test("compare");
        busy = 1'b1;
        tick(4);
        e1 = exp_pair();
        fork
            host.frame(STATUS_READ_OPCODE, 32);
            begin
                #(20 * 400);
                @(posedge clk);
                #1 busy = 1'b0;
            end
        join
        e2 = exp_pair();
        check(host.rx_q, {e1, e2});
        end_test("busy");
        host.frame(8'h9F, 16);
        check({31'h0, host.oe_seen_q}, 32'h0);
        end_test("refused");
        host.frame(STATUS_READ_OPCODE, 3);
        check({31'h0, so_oe}, 32'h0);
        check({29'h0, host.rx_q[2:0]}, {29'h0, e2[15:13]});
        end_test("deselect");
        finish_test();
    end
endmodule
`default_nettype wire
